// ---- bit_test_clear_pkg.sv ----
// constants and types shared by the test-and-clear-bit decode and execute logic
package bit_test_clear_pkg;

	// opcode word layout
	localparam int        OP_HI_MSB      = 15;
	localparam int        OP_HI_LSB      = 6;
	localparam logic [9:0] STATIC_PATTERN = 10'h022;
	localparam int        DYN_TOP_MSB    = 15;
	localparam int        DYN_TOP_LSB    = 12;
	localparam logic [3:0] DYN_TOP_PATTERN = 4'h0;
	localparam int        DYN_SUB_MSB    = 8;
	localparam int        DYN_SUB_LSB    = 6;
	localparam logic [2:0] DYN_SUB_PATTERN = 3'h6;
	localparam int        NUM_REG_MSB    = 11;
	localparam int        NUM_REG_LSB    = 9;
	localparam int        EA_MODE_MSB    = 5;
	localparam int        EA_MODE_LSB    = 3;
	localparam int        EA_REG_MSB     = 2;
	localparam int        EA_REG_LSB     = 0;

	// extension word layout
	localparam int        EXT_HI_MSB     = 15;
	localparam int        EXT_HI_LSB     = 8;
	localparam int        EXT_NUM_MSB    = 7;
	localparam int        EXT_NUM_LSB    = 0;
	localparam logic [7:0] EXT_HI_ZERO    = 8'h00;

	// destination addressing modes
	localparam logic [2:0] MODE_DATA_REG  = 3'h0;
	localparam logic [2:0] MODE_IND       = 3'h2;
	localparam logic [2:0] MODE_POSTINC   = 3'h3;
	localparam logic [2:0] MODE_PREDEC    = 3'h4;
	localparam logic [2:0] MODE_DISP      = 3'h5;
	localparam logic [2:0] MODE_INDEX     = 3'h6;
	localparam logic [2:0] MODE_EXTRA     = 3'h7;
	localparam logic [2:0] REG_ABS_WORD   = 3'h0;
	localparam logic [2:0] REG_ABS_LONG   = 3'h1;

	// operand widths
	localparam int        LONG_BITS      = 32;
	localparam int        BYTE_BITS      = 8;

	// condition code bit positions
	localparam int        CCR_C          = 0;
	localparam int        CCR_V          = 1;
	localparam int        CCR_Z          = 2;
	localparam int        CCR_N          = 3;
	localparam int        CCR_X          = 4;
	localparam logic [4:0] CCR_RESET      = 5'h00;

	// sequencer states
	typedef enum logic [3:0] {
		S_IDLE,
		S_EXT,
		S_NUM_REQ,
		S_NUM_CAP,
		S_DST_REQ,
		S_DST_CAP,
		S_MEM_RD,
		S_FLAG,
		S_CCR,
		S_REG_WR,
		S_MEM_WR,
		S_ILL
	} seq_state_t;

endpackage

// ---- btc_decode.sv ----
// opcode classifier for the test-and-clear-bit instruction
`timescale 1ns/1ps
`default_nettype none
module btc_decode
	import bit_test_clear_pkg::*;
(
	input  wire logic [15:0] op_word,    // opcode word
	output logic             is_static,  // immediate bit number form
	output logic             is_dynamic, // register bit number form
	output logic             ea_legal,   // destination is data alterable
	output logic             is_long     // data register destination
);
	logic [2:0] mode;
	logic [2:0] reg_f;

	// field split
	assign mode  = op_word[EA_MODE_MSB:EA_MODE_LSB];
	assign reg_f = op_word[EA_REG_MSB:EA_REG_LSB];

	assign is_static = (op_word[OP_HI_MSB:OP_HI_LSB] == STATIC_PATTERN);

	assign is_dynamic = (op_word[DYN_TOP_MSB:DYN_TOP_LSB] == DYN_TOP_PATTERN)
		&& (op_word[DYN_SUB_MSB:DYN_SUB_LSB] == DYN_SUB_PATTERN);

	always_comb
	begin
		unique case (mode)
			MODE_DATA_REG, MODE_IND, MODE_POSTINC, MODE_PREDEC,
			MODE_DISP, MODE_INDEX: ea_legal = 1'b1;
			MODE_EXTRA:            ea_legal = (reg_f == REG_ABS_WORD) || (reg_f == REG_ABS_LONG);
			default:               ea_legal = 1'b0; // pointer register direct
		endcase
	end

	assign is_long = (mode == MODE_DATA_REG);
endmodule
`default_nettype wire

// ---- btc_bit_unit.sv ----
// bit selector that tests one operand bit and clears it
`timescale 1ns/1ps
`default_nettype none
module btc_bit_unit
	import bit_test_clear_pkg::*;
#(
	parameter int LONG_W = LONG_BITS, // register operand width
	parameter int BYTE_W = BYTE_BITS  // memory operand width
)
(
	input  wire logic [LONG_W-1:0] operand,     // destination value
	input  wire logic [7:0]        bit_num,     // raw bit number
	input  wire logic              is_long,     // long or byte operation
	output logic                   tested_zero, // selected bit was zero
	output logic [LONG_W-1:0]      cleared      // operand with bit cleared
);
	logic [LONG_W-1:0] mask;

	// widths the modulo selection cannot serve, refused at elaboration
	if (LONG_W != 32 || BYTE_W != 8)
	begin : g_bad_width
		$error("btc_bit_unit: widths must be 32 and 8");
	end

	// one select line per bit, bit 0 is lsb
	for (genvar i = 0; i < LONG_W; i++)
	begin : g_bit
		// modulo 32 for long, modulo 8 for byte
		assign mask[i] = is_long ? (bit_num[4:0] == 5'(i))
			: ((i < BYTE_W) && (bit_num[2:0] == 3'(i)));
	end

	assign tested_zero = ~|(operand & mask);
	assign cleared     = operand & ~mask;
endmodule
`default_nettype wire

// ---- bit_test_clear_op.sv ----
// sequencer that decodes and executes the test-and-clear-bit instruction
//
// Overview of operation
// - test bit, update flag, then write back
// - zero flag from tested bit, others kept
// - register destination: long, bit modulo 32
// - memory destination: byte, bit modulo 8
// - bit zero is least significant bit
// - static opcode bits 15..6 are 0000100010
// - static bit number from extension low byte
// - dynamic form: number from selected data_register
// - only data alterable destinations accepted
// - data_register direct is the only long case
`timescale 1ns/1ps
`default_nettype none
module bit_test_clear_op
	import bit_test_clear_pkg::*;
(
	input  wire logic        CORE_CLK,     // core clock, 200 MHz
	input  wire logic        RST_N,        // synchronous reset, active low
	input  wire logic        OP_VALID,     // opcode word offered
	input  wire logic [15:0] OP_WORD,      // opcode word
	output logic             OP_READY,     // opcode word taken when high
	input  wire logic        EXT_VALID,    // extension word offered
	input  wire logic [15:0] EXT_WORD,     // extension word
	output logic             EXT_READY,    // extension word taken when high
	output logic             REG_RD_EN,    // data_register read strobe
	output logic [2:0]       REG_RD_SEL,   // data_register read index
	input  wire logic [31:0] REG_RD_DATA,  // read data, one cycle after strobe
	output logic [2:0]       EA_MODE,      // destination mode for address unit
	output logic [2:0]       EA_REG,       // destination register field
	output logic             MEM_RD_REQ,   // byte read request
	input  wire logic        MEM_RD_VALID, // byte read done
	input  wire logic [7:0]  MEM_RD_DATA,  // byte read data
	output logic             MEM_WR_REQ,   // byte write request
	output logic [7:0]       MEM_WR_DATA,  // byte write data
	input  wire logic        MEM_WR_ACK,   // byte write done
	input  wire logic [4:0]  CCR_IN,       // current condition codes
	output logic [4:0]       CCR_OUT,      // new condition codes
	output logic             CCR_WR,       // condition code write strobe
	output logic             REG_WR_EN,    // data_register write strobe
	output logic [2:0]       REG_WR_SEL,   // data_register write index
	output logic [31:0]      REG_WR_DATA,  // data_register write data
	output logic             ILLEGAL_EXC,  // illegal instruction pulse
	output logic             DONE,         // instruction complete pulse
	output logic             BUSY          // instruction in progress
);
	seq_state_t  state_q;
	logic [2:0]  num_reg_q;
	logic [2:0]  ea_mode_q;
	logic [2:0]  ea_reg_q;
	logic        is_long_q;
	logic [7:0]  bit_num_q;
	logic [31:0] operand_q;
	logic [31:0] result_q;
	logic [4:0]  ccr_q;
	logic        dec_static;
	logic        dec_dynamic;
	logic        dec_legal;
	logic        dec_long;
	logic        tested_zero;
	logic [31:0] cleared;
	logic        op_take;
	logic        ext_take;

	// opcode classification
	btc_decode u_decode (
		.op_word    (OP_WORD),
		.is_static  (dec_static),
		.is_dynamic (dec_dynamic),
		.ea_legal   (dec_legal),
		.is_long    (dec_long)
	);

	// bit test and clear on the captured operand
	btc_bit_unit #(
		.LONG_W (LONG_BITS),
		.BYTE_W (BYTE_BITS)
	) u_bit (
		.operand     (operand_q),
		.bit_num     (bit_num_q),
		.is_long     (is_long_q),
		.tested_zero (tested_zero),
		.cleared     (cleared)
	);

	// handshake terms
	assign op_take  = OP_VALID && OP_READY;
	assign ext_take = EXT_VALID && EXT_READY;

	// sequencer
	always_ff @(posedge CORE_CLK)
	begin
		if (!RST_N)
			state_q <= S_IDLE;
		else
		begin
			unique case (state_q)
				S_IDLE:
				begin
					if (op_take && (dec_static || dec_dynamic) && !dec_legal)
						state_q <= S_ILL;
					else if (op_take && dec_static)
						state_q <= S_EXT;
					// dynamic form reads the number register
					else if (op_take && dec_dynamic)
						state_q <= S_NUM_REQ;
				end
				S_EXT:
				begin
					// upper byte of extension must be zero
					if (ext_take && EXT_WORD[EXT_HI_MSB:EXT_HI_LSB] != EXT_HI_ZERO)
						state_q <= S_ILL;
					else if (ext_take)
						state_q <= is_long_q ? S_DST_REQ : S_MEM_RD;
				end
				S_NUM_REQ: state_q <= S_NUM_CAP;
				// long goes to register, byte to memory
				S_NUM_CAP: state_q <= is_long_q ? S_DST_REQ : S_MEM_RD;
				S_DST_REQ: state_q <= S_DST_CAP;
				S_DST_CAP: state_q <= S_FLAG;
				S_MEM_RD:
				begin
					if (MEM_RD_VALID)
						state_q <= S_FLAG;
				end
				S_FLAG:    state_q <= S_CCR;
				// write back only after the flag update
				S_CCR:     state_q <= is_long_q ? S_REG_WR : S_MEM_WR;
				S_REG_WR:  state_q <= S_IDLE;
				S_MEM_WR:
				begin
					if (MEM_WR_ACK)
						state_q <= S_IDLE;
				end
				S_ILL:     state_q <= S_IDLE;
				default:   state_q <= S_IDLE; // unused codes fall back to idle
			endcase
		end
	end

	// opcode fields captured when a word is taken
	always_ff @(posedge CORE_CLK)
	begin
		if (!RST_N)
		begin
			num_reg_q <= 3'h0;
			ea_mode_q <= 3'h0;
			ea_reg_q  <= 3'h0;
			is_long_q <= 1'b0;
		end
		else if (op_take)
		begin
			num_reg_q <= OP_WORD[NUM_REG_MSB:NUM_REG_LSB];
			ea_mode_q <= OP_WORD[EA_MODE_MSB:EA_MODE_LSB];
			ea_reg_q  <= OP_WORD[EA_REG_MSB:EA_REG_LSB];
			is_long_q <= dec_long;
		end
	end

	// bit number from extension word or number register
	always_ff @(posedge CORE_CLK)
	begin
		if (!RST_N)
			bit_num_q <= 8'h00;
		else if (ext_take)
			bit_num_q <= EXT_WORD[EXT_NUM_MSB:EXT_NUM_LSB];
		// low byte of the number register covers both moduli
		else if (state_q == S_NUM_CAP)
			bit_num_q <= REG_RD_DATA[7:0];
	end

	// destination operand capture
	always_ff @(posedge CORE_CLK)
	begin
		if (!RST_N)
			operand_q <= 32'h0000_0000;
		else if (state_q == S_DST_CAP)
			operand_q <= REG_RD_DATA;
		else if (state_q == S_MEM_RD && MEM_RD_VALID)
			operand_q <= {24'h00_0000, MEM_RD_DATA};
	end

	// flag and result computed together in the flag state
	always_ff @(posedge CORE_CLK)
	begin
		if (!RST_N)
		begin
			ccr_q    <= CCR_RESET;
			result_q <= 32'h0000_0000;
		end
		else if (state_q == S_FLAG)
		begin
			ccr_q        <= CCR_IN;
			ccr_q[CCR_Z] <= tested_zero;
			result_q     <= cleared;
		end
	end

	// handshakes and strobes decoded from state, DONE also gated by MEM_WR_ACK
	assign OP_READY    = (state_q == S_IDLE);
	assign EXT_READY   = (state_q == S_EXT);
	assign REG_RD_EN   = (state_q == S_NUM_REQ) || (state_q == S_DST_REQ);
	assign REG_RD_SEL  = (state_q == S_NUM_REQ) ? num_reg_q : ea_reg_q;
	assign MEM_RD_REQ  = (state_q == S_MEM_RD);
	assign MEM_WR_REQ  = (state_q == S_MEM_WR);
	assign CCR_WR      = (state_q == S_CCR);
	assign REG_WR_EN   = (state_q == S_REG_WR);
	assign ILLEGAL_EXC = (state_q == S_ILL);
	assign DONE        = REG_WR_EN || (MEM_WR_REQ && MEM_WR_ACK);
	assign BUSY        = (state_q != S_IDLE);

	// data outputs straight from registers
	assign EA_MODE     = ea_mode_q;
	assign EA_REG      = ea_reg_q;
	assign CCR_OUT     = ccr_q;
	assign REG_WR_SEL  = ea_reg_q;
	assign REG_WR_DATA = result_q;
	assign MEM_WR_DATA = result_q[7:0];

	// checks on the sequencer
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);

	logic ref_bit;
	assign ref_bit = is_long_q ? operand_q[bit_num_q[4:0]] : operand_q[bit_num_q[2:0]];

	flag_before_write_a: assert property (
		$rose(REG_WR_EN) || $rose(MEM_WR_REQ) |-> $past(CCR_WR))
		else $error("write back without a preceding flag update");

	zero_flag_value_a: assert property (
		$rose(CCR_WR) |-> CCR_OUT[CCR_Z] == !$past(ref_bit))
		else $error("zero flag does not match tested bit");

	other_flags_kept_a: assert property (
		CCR_WR |-> {CCR_OUT[CCR_X], CCR_OUT[CCR_N], CCR_OUT[CCR_V], CCR_OUT[CCR_C]}
			== $past({CCR_IN[CCR_X], CCR_IN[CCR_N], CCR_IN[CCR_V], CCR_IN[CCR_C]}))
		else $error("flags other than zero changed");

	long_clear_a: assert property (
		REG_WR_EN |-> REG_WR_DATA == (operand_q & ~(32'h0000_0001 << bit_num_q[4:0])))
		else $error("register write back is not a modulo 32 clear");

	byte_clear_a: assert property (
		MEM_WR_REQ |-> MEM_WR_DATA == (operand_q[7:0] & ~(8'h01 << bit_num_q[2:0])))
		else $error("memory write back is not a modulo 8 clear");

	static_needs_ext_a: assert property (
		op_take && OP_WORD[15:6] == 10'h022 && OP_WORD[5:3] == 3'h2 |=> EXT_READY)
		else $error("static form did not wait for extension word");

	ext_high_byte_a: assert property (
		ext_take && EXT_WORD[15:8] != 8'h00 |=> ILLEGAL_EXC ##1 OP_READY)
		else $error("nonzero extension upper byte accepted");

	dynamic_reg_read_a: assert property (
		op_take && OP_WORD[15:12] == 4'h0 && OP_WORD[8:6] == 3'h6 && OP_WORD[5:3] == 3'h2
			|=> REG_RD_EN && REG_RD_SEL == $past(OP_WORD[11:9]))
		else $error("dynamic form did not read the number register");

	bad_mode_illegal_a: assert property (
		op_take && (OP_WORD[15:6] == 10'h022 || (OP_WORD[15:12] == 4'h0
			&& OP_WORD[8:6] == 3'h6)) && OP_WORD[5:3] == 3'h1 |=> ILLEGAL_EXC)
		else $error("pointer register destination not refused");

	legal_mode_runs_a: assert property (
		op_take && OP_WORD[15:6] == 10'h022 && OP_WORD[5:0] == 6'h39 |=> !ILLEGAL_EXC)
		else $error("absolute long destination refused");

	size_by_mode_a: assert property (
		(REG_WR_EN |-> ea_mode_q == 3'h0) and (MEM_RD_REQ |-> ea_mode_q != 3'h0))
		else $error("operation size does not follow destination mode");

	static_bit_num_a: assert property (
		ext_take && EXT_WORD[15:8] == 8'h00 |=> bit_num_q == $past(EXT_WORD[7:0]))
		else $error("static bit number not taken from extension low byte");

	legal_dest_runs_a: assert property (
		op_take && (OP_WORD[15:6] == 10'h022 || (OP_WORD[15:12] == 4'h0
			&& OP_WORD[8:6] == 3'h6)) && OP_WORD[5:3] != 3'h1
			&& (OP_WORD[5:3] != 3'h7 || OP_WORD[2:1] == 2'h0) |=> !ILLEGAL_EXC)
		else $error("data alterable destination refused");

	lsb_clear_a: assert property (
		REG_WR_EN && bit_num_q[4:0] == 5'h00 |-> !REG_WR_DATA[0])
		else $error("bit zero does not address the least significant bit");

	// covers of the main flows
	static_mem_done_c: cover property (
		ext_take ##[1:20] MEM_WR_REQ && MEM_WR_ACK);
	dynamic_reg_done_c: cover property (
		REG_RD_EN ##2 REG_RD_EN ##4 REG_WR_EN);
	static_reg_done_c: cover property (
		EXT_READY ##1 REG_RD_EN ##4 REG_WR_EN);
	mem_wait_c: cover property (MEM_RD_REQ && !MEM_RD_VALID ##1 MEM_RD_REQ);
	illegal_seen_c: cover property (ILLEGAL_EXC);
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the test-and-clear-bit sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import bit_test_clear_pkg::*;
;
	logic        clk, rst_n, op_valid, ext_valid, rd_valid, wr_ack;
	logic [15:0] op_word, ext_word;
	logic [31:0] rd_data, wr_data, reg_got;
	logic [31:0] regs [8];
	logic [7:0]  mem_rd_data, mem_byte, wr_byte, mem_wr_data;
	logic [4:0]  ccr_in, ccr_out, ccr_got;
	logic [2:0]  rd_sel, ea_mode, ea_reg, wr_sel, sel_got;
	logic        op_ready, ext_ready, reg_rd_en, mem_rd_req, mem_wr_req;
	logic        ccr_wr, reg_wr_en, illegal, done, busy, cnt_clr;
	int          err_total, check_count, lat, wait_n, cyc, ccr_cyc, wr_cyc;
	int          ccr_n, wr_n, done_n, ill_n;

	bit_test_clear_op dut (
		.CORE_CLK(clk), .RST_N(rst_n), .OP_VALID(op_valid), .OP_WORD(op_word),
		.OP_READY(op_ready), .EXT_VALID(ext_valid), .EXT_WORD(ext_word),
		.EXT_READY(ext_ready), .REG_RD_EN(reg_rd_en), .REG_RD_SEL(rd_sel),
		.REG_RD_DATA(rd_data), .EA_MODE(ea_mode), .EA_REG(ea_reg),
		.MEM_RD_REQ(mem_rd_req), .MEM_RD_VALID(rd_valid), .MEM_RD_DATA(mem_rd_data),
		.MEM_WR_REQ(mem_wr_req), .MEM_WR_DATA(mem_wr_data), .MEM_WR_ACK(wr_ack),
		.CCR_IN(ccr_in), .CCR_OUT(ccr_out), .CCR_WR(ccr_wr), .REG_WR_EN(reg_wr_en),
		.REG_WR_SEL(wr_sel), .REG_WR_DATA(wr_data), .ILLEGAL_EXC(illegal),
		.DONE(done), .BUSY(busy)
	);

	// 200 MHz core clock
	always #2.5 clk = ~clk;

	// register file: data one cycle after strobe, scrambled otherwise
	always @(posedge clk)
	begin
		if (!rst_n)
			rd_data <= 32'h0;
		else if (reg_rd_en)
			rd_data <= regs[rd_sel];
		else
			rd_data <= ~rd_data;
	end

	// memory: answers after lat idle cycles, data scrambled outside the answer
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			rd_valid <= 1'b0;
			wr_ack <= 1'b0;
			mem_rd_data <= 8'h00;
			wait_n <= 0;
		end
		else
		begin
			rd_valid <= 1'b0;
			wr_ack <= 1'b0;
			mem_rd_data <= ~mem_rd_data;
			if ((mem_rd_req && !rd_valid) || (mem_wr_req && !wr_ack))
			begin
				if (wait_n < lat)
					wait_n <= wait_n + 1;
				else
				begin
					wait_n <= 0;
					rd_valid <= mem_rd_req;
					wr_ack <= mem_wr_req;
					if (mem_rd_req)
						mem_rd_data <= mem_byte;
				end
			end
		end
	end

	// monitor of flag updates, write backs and completions
	// captures are voided per instruction so a missing update cannot pass
	always @(posedge clk)
	begin
		cyc <= rst_n ? cyc + 1 : 0;
		if (!rst_n || cnt_clr)
		begin
			{ccr_n, wr_n, done_n, ill_n} <= '0;
			{ccr_got, wr_byte, reg_got, sel_got} <= 'x;
		end
		else
		begin
			if (ccr_wr)
			begin
				ccr_got <= ccr_out;
				ccr_n <= ccr_n + 1;
				ccr_cyc <= cyc;
			end
			if (reg_wr_en)
			begin
				reg_got <= wr_data;
				sel_got <= wr_sel;
				wr_n <= wr_n + 1;
				wr_cyc <= cyc;
			end
			if (mem_wr_req && wr_ack)
			begin
				wr_byte <= mem_wr_data;
				wr_n <= wr_n + 1;
				wr_cyc <= cyc;
			end
			if (done)
				done_n <= done_n + 1;
			if (illegal)
				ill_n <= ill_n + 1;
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("checks=%0d mismatches=%0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic bound(input int n, input int lim);
		if (n >= lim)
		begin
			err_total++;
			summarize();
		end
	endtask

	// one instruction: offer opcode, hold extension word, wait for the end
	task automatic run(input logic [15:0] op, input logic [15:0] ext);
		int n;
		@(posedge clk);
		cnt_clr <= 1'b1;
		@(posedge clk);
		cnt_clr <= 1'b0;
		op_valid <= 1'b1;
		op_word <= op;
		ext_valid <= 1'b1;
		ext_word <= ext;
		n = 0;
		@(negedge clk);
		while (op_ready !== 1'b1 && n < 50)
		begin
			@(negedge clk);
			n++;
		end
		bound(n, 50);
		@(posedge clk);
		op_valid <= 1'b0;
		@(negedge clk);
		check(32'({busy, op_ready}), 32'h2);
		n = 0;
		while (done_n + ill_n == 0 && n < 200)
		begin
			@(negedge clk);
			n++;
		end
		bound(n, 200);
		@(posedge clk);
		ext_valid <= 1'b0;
	endtask

	task automatic t_static_mem();
		@(posedge clk);
		ccr_in <= 5'h1f;
		mem_byte <= 8'h08;
		lat <= 3;
		run(16'h0893, 16'h000b);
		check(32'(ea_mode), 32'h2);
		check(32'(ea_reg), 32'h3);
		check(32'(wr_byte), 32'h00);
		check(32'(ccr_got), 32'h1b);
		// lat + 2 request cycles from the flag strobe to the acknowledge
		check(32'(wr_cyc - ccr_cyc), 32'h5);
		check(32'(done_n), 32'h1);
	endtask

	task automatic t_static_zero();
		@(posedge clk);
		ccr_in <= 5'h00;
		mem_byte <= 8'hf7;
		lat <= 0;
		run(16'h08b8, 16'h0003);
		check(32'(ccr_got), 32'h04);
		check(32'(wr_byte), 32'hf7);
		check(32'(wr_n), 32'h1);
	endtask

	task automatic t_dyn_reg();
		@(posedge clk);
		ccr_in <= 5'h1f;
		regs[5] <= 32'h0000_003f;
		regs[2] <= 32'h8000_0001;
		run(16'h0b82, 16'h0000);
		check(reg_got, 32'h0000_0001);
		check(32'(sel_got), 32'h2);
		check(32'(ccr_got), 32'h1b);
		check(32'(wr_cyc - ccr_cyc), 32'h1);
	endtask

	task automatic t_static_lsb();
		@(posedge clk);
		ccr_in <= 5'h1b;
		regs[4] <= 32'hffff_fffe;
		run(16'h0884, 16'h0020);
		check(reg_got, 32'hffff_fffe);
		check(32'(ccr_got), 32'h1f);
		check(32'(sel_got), 32'h4);
	endtask

	// every memory mode but absolute word is run here as a byte access
	task automatic t_dyn_modes();
		logic [5:0] eas [6];
		eas = '{6'h10, 6'h19, 6'h22, 6'h2b, 6'h34, 6'h39};
		for (int i = 0; i < 6; i++)
		begin
			@(posedge clk);
			ccr_in <= 5'h00;
			regs[1] <= 32'hffff_ff0f;
			mem_byte <= 8'h81;
			lat <= (i % 2) * 2;
			run(16'h0380 | 16'(eas[i]), 16'h0000);
			check(32'({ea_mode, ea_reg}), 32'(eas[i]));
			check(32'(wr_byte), 32'h01);
			check(32'(ccr_got), 32'h00);
			check(32'(done_n), 32'h1);
		end
	endtask

	task automatic t_illegal();
		logic [5:0] bad [5];
		bad = '{6'h08, 6'h0f, 6'h3a, 6'h3b, 6'h3c};
		for (int i = 0; i < 10; i++)
		begin
			run((i < 5 ? 16'h0880 : 16'h0380) | 16'(bad[i % 5]), 16'h0001);
			check(32'(ill_n), 32'h1);
			check(32'(ccr_n + wr_n + done_n), 32'h0);
		end
		run(16'h0890, 16'h0103);
		check(32'(ill_n), 32'h1);
		check(32'(ccr_n + wr_n), 32'h0);
	endtask

	initial
	begin
		clk = 1'b0;
		rst_n = 1'b0;
		op_valid = 1'b0;
		op_word = 16'h0000;
		ext_valid = 1'b0;
		ext_word = 16'h0000;
		ccr_in = 5'h00;
		mem_byte = 8'h00;
		cnt_clr = 1'b0;
		regs = '{default: 32'h0};
		{err_total, check_count, lat} = '0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		check(32'({op_ready, busy}), 32'h2);
		t_static_mem();
		t_static_zero();
		t_dyn_reg();
		t_static_lsb();
		t_dyn_modes();
		t_illegal();
		summarize();
	end
endmodule
`default_nettype wire
